// File: pkg/dcd_pkg.sv
// What this block does
// RQ1 - A command code that is not recognised acts as a no-operation: nothing changes and no parameter is stored.
// RQ2 - Codes B0h to D9h and DEh to FFh are decoded as supplier-reserved, apart from the user commands.
// RQ3 - Each reserved code is set before shipment to be available or to act as no-operation, no-operation by default.
// RQ4 - In sleep-out the display-state commands are held pending and take effect at the next vertical sync.
// RQ5 - For memory access control only bit 4 waits for vertical sync in sleep-out; the other bits apply at once.
// RQ6 - In sleep-in the display-state commands take effect at once.
// RQ7 - The reads 09h to 0Fh answer at once in either sleep state; 09h to 0Bh return current values, 0Ch to 0Fh only zero bytes.
// RQ8 - Command E2h takes 16 bytes, red coarse entry in the upper nibble and blue in the lower, stored per index.
// RQ9 - Command E3h takes 64 bytes, red fine entry in the upper nibble and blue in the lower, indices 0 to 63.
// RQ10 - Commands E0h and E1h take 15 bytes each, keeping the narrow low fields and dropping unused upper bits.
// RQ11 - The fourth identification read returns a dummy byte, a zero byte, then two device code bytes.
package dcd_pkg;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_RD_STATUS = 8'h09;
  localparam logic [7:0] CMD_RD_POWER = 8'h0a;
  localparam logic [7:0] CMD_RD_MAC = 8'h0b;
  localparam logic [7:0] CMD_RD_LAST = 8'h0f;
  localparam logic [7:0] CMD_SLEEP_IN = 8'h10;
  localparam logic [7:0] CMD_SLEEP_OUT = 8'h11;
  localparam logic [7:0] CMD_PARTIAL = 8'h12;
  localparam logic [7:0] CMD_NORMAL = 8'h13;
  localparam logic [7:0] CMD_GAMMA_SET = 8'h26;
  localparam logic [7:0] CMD_DISP_OFF = 8'h28;
  localparam logic [7:0] CMD_DISP_ON = 8'h29;
  localparam logic [7:0] CMD_AREA = 8'h30;
  localparam logic [7:0] CMD_MEM_ACC = 8'h36;
  localparam logic [7:0] CMD_IDLE_OFF = 8'h38;
  localparam logic [7:0] CMD_IDLE_ON = 8'h39;
  localparam logic [7:0] CMD_RD_ID4 = 8'hd3;
  localparam logic [7:0] CMD_POS_GAMMA = 8'he0;
  localparam logic [7:0] CMD_NEG_GAMMA = 8'he1;
  localparam logic [7:0] CMD_COARSE_GAMMA = 8'he2;
  localparam logic [7:0] CMD_FINE_GAMMA = 8'he3;
  localparam logic [7:0] FACT_LO0 = 8'hb0;
  localparam logic [7:0] FACT_HI0 = 8'hd9;
  localparam logic [7:0] FACT_LO1 = 8'hde;
  localparam logic [7:0] FACT_HI1 = 8'hff;
  localparam int ANALOG_LEN = 15;
  localparam int COARSE_LEN = 16;
  localparam int FINE_LEN = 64;
  localparam int AREA_LEN = 4;
  localparam int MAC_DEFER_BIT = 4;
  localparam logic [7:0] RD_DUMMY = 8'h00;
  localparam logic [7:0] ID4_FIXED = 8'h00;
  localparam logic [7:0] RST_GAMMA_SEL = 8'h01;
  localparam logic [7:0] RST_MAC = 8'h00;
  localparam logic [15:0] RST_AREA_START = 16'h0000;
  localparam logic [15:0] RST_AREA_END = 16'h0000;
  localparam logic [255:0] RST_FACT_AVAIL = '0;
  typedef enum logic [3:0] {
    CTX_IDLE, CTX_GAMMA_SET, CTX_AREA, CTX_MAC, CTX_POS, CTX_NEG,
    CTX_COARSE, CTX_FINE, CTX_READ
  } dcd_ctx_t;
endpackage

// File: rtl/dcd_decoder.sv
`timescale 1ns/1ps
module dcd_decoder #(
  // Arbitrary neutral device codes
  parameter logic [7:0] ID4_CODE_HI = 8'h5a,
  parameter logic [7:0] ID4_CODE_LO = 8'ha5,
  // One bit per code; only reserved codes are honoured
  parameter logic [255:0] FACT_AVAIL = dcd_pkg::RST_FACT_AVAIL
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  // Host write and read strobes
  input wire logic I_WR_STB,
  input wire logic I_IS_PARAM,
  input wire logic [7:0] I_WR_DATA,
  input wire logic I_RD_STB,
  output logic O_RD_VALID,
  output logic [7:0] O_RD_DATA,
  // Panel timing
  input wire logic I_VSYNC,
  // Applied display state
  output logic O_SLEEP_IN,
  output logic O_PARTIAL,
  output logic O_DISP_ON,
  output logic O_IDLE,
  output logic [7:0] O_GAMMA_SEL,
  output logic [15:0] O_AREA_START,
  output logic [15:0] O_AREA_END,
  output logic [7:0] O_MEMORY_ACCESS_CONTROL,
  // Reserved command report
  output logic O_FACTORY_STB,
  output logic [7:0] O_FACTORY_CODE,
  // Gamma table lookup
  input wire logic [5:0] I_LUT_IDX,
  output logic [7:0] O_POS_GAMMA,
  output logic [7:0] O_NEG_GAMMA,
  output logic [3:0] O_RED_COARSE_GAMMA_ENTRY,
  output logic [3:0] O_BLUE_COARSE_GAMMA_ENTRY,
  output logic [3:0] O_RED_FINE_GAMMA_ENTRY,
  output logic [3:0] O_BLUE_FINE_GAMMA_ENTRY
);
  import dcd_pkg::*;

  function automatic logic is_reserved(input logic [7:0] c);
    return (c >= FACT_LO0 && c <= FACT_HI0) || (c >= FACT_LO1);
  endfunction

  // Field width of each positive/negative gamma byte
  function automatic logic [7:0] analog_mask(input logic [3:0] i);
    case (i)
      4'd1, 4'd2, 4'd12, 4'd13: analog_mask = 8'h3f;
      4'd4, 4'd10: analog_mask = 8'h1f;
      4'd6, 4'd8: analog_mask = 8'h7f;
      4'd7: analog_mask = 8'hff;
      default: analog_mask = 8'h0f;
    endcase
  endfunction

  dcd_ctx_t ctx_reg, ctx_next;
  logic [6:0] idx_reg, idx_next;
  logic [7:0] rd_cmd_reg, rd_cmd_next;
  // Shadow copy written by the host; applied copy drives the panel
  logic sh_sleep_reg, sh_sleep_next, sh_part_reg, sh_part_next;
  logic sh_on_reg, sh_on_next, sh_idle_reg, sh_idle_next;
  logic sh_mac4_reg, sh_mac4_next;
  logic [7:0] sh_gsel_reg, sh_gsel_next;
  logic [31:0] sh_area_reg, sh_area_next;
  logic sleep_next, part_next, on_next, idle_next;
  logic [7:0] gsel_next, mac_next;
  logic [15:0] as_next, ae_next;
  logic fact_stb_next, rd_valid_next;
  logic [7:0] fact_code_next, rd_data_next;
  logic pos_we, neg_we, coarse_we, fine_we;
  logic [7:0] pos_tab [ANALOG_LEN];
  logic [7:0] neg_tab [ANALOG_LEN];
  logic [7:0] coarse_tab [COARSE_LEN];
  logic [7:0] fine_tab [FINE_LEN];
  logic apply;
  logic [7:0] power_byte;

  always_comb begin
    power_byte = {1'b0, O_IDLE, O_PARTIAL, ~O_SLEEP_IN, ~O_PARTIAL,
                  O_DISP_ON, 2'b00};
    // In sleep-in changes apply at once; in sleep-out they wait for the frame boundary
    // RQ6 immediate in sleep
    // RQ4 defer to vsync
    apply = O_SLEEP_IN | I_VSYNC;
    ctx_next = ctx_reg;
    idx_next = idx_reg;
    rd_cmd_next = rd_cmd_reg;
    sh_sleep_next = sh_sleep_reg;
    sh_part_next = sh_part_reg;
    sh_on_next = sh_on_reg;
    sh_idle_next = sh_idle_reg;
    sh_mac4_next = sh_mac4_reg;
    sh_gsel_next = sh_gsel_reg;
    sh_area_next = sh_area_reg;
    fact_stb_next = 1'b0;
    fact_code_next = O_FACTORY_CODE;
    rd_valid_next = 1'b0;
    rd_data_next = O_RD_DATA;
    pos_we = 1'b0;
    neg_we = 1'b0;
    coarse_we = 1'b0;
    fine_we = 1'b0;
    mac_next = O_MEMORY_ACCESS_CONTROL;
    sleep_next = O_SLEEP_IN;
    part_next = O_PARTIAL;
    on_next = O_DISP_ON;
    idle_next = O_IDLE;
    gsel_next = O_GAMMA_SEL;
    as_next = O_AREA_START;
    ae_next = O_AREA_END;
    if (I_WR_STB && !I_IS_PARAM) begin
      ctx_next = CTX_IDLE;
      idx_next = '0;
      case (I_WR_DATA)
        CMD_SLEEP_IN: sh_sleep_next = 1'b1;
        CMD_SLEEP_OUT: sh_sleep_next = 1'b0;
        CMD_PARTIAL: sh_part_next = 1'b1;
        CMD_NORMAL: sh_part_next = 1'b0;
        CMD_DISP_OFF: sh_on_next = 1'b0;
        CMD_DISP_ON: sh_on_next = 1'b1;
        CMD_IDLE_OFF: sh_idle_next = 1'b0;
        CMD_IDLE_ON: sh_idle_next = 1'b1;
        CMD_GAMMA_SET: ctx_next = CTX_GAMMA_SET;
        CMD_AREA: ctx_next = CTX_AREA;
        CMD_MEM_ACC: ctx_next = CTX_MAC;
        CMD_POS_GAMMA: ctx_next = CTX_POS;
        CMD_NEG_GAMMA: ctx_next = CTX_NEG;
        CMD_COARSE_GAMMA: ctx_next = CTX_COARSE;
        CMD_FINE_GAMMA: ctx_next = CTX_FINE;
        default: begin
          // RQ7 reads see live state
          if ((I_WR_DATA >= CMD_RD_STATUS && I_WR_DATA <= CMD_RD_LAST) ||
              I_WR_DATA == CMD_RD_ID4) begin
            ctx_next = CTX_READ;
            rd_cmd_next = I_WR_DATA;
          // RQ2 reserved range decode
          // RQ3 available only if set
          end else if (is_reserved(I_WR_DATA) && FACT_AVAIL[I_WR_DATA]) begin
            fact_stb_next = 1'b1;
            fact_code_next = I_WR_DATA;
          end
          // RQ1 unknown acts as no-op
        end
      endcase
    end else if (I_WR_STB) begin
      idx_next = (idx_reg == 7'h7f) ? idx_reg : idx_reg + 7'd1;
      case (ctx_reg)
        CTX_GAMMA_SET: if (idx_reg == 7'd0) sh_gsel_next = I_WR_DATA;
        CTX_AREA: begin
          if (idx_reg < 7'(AREA_LEN))
            sh_area_next = {sh_area_reg[23:0], I_WR_DATA};
        end
        CTX_MAC: begin
          if (idx_reg == 7'd0) begin
            // RQ5 only bit 4 deferred
            mac_next = I_WR_DATA;
            mac_next[MAC_DEFER_BIT] = O_MEMORY_ACCESS_CONTROL[MAC_DEFER_BIT];
            sh_mac4_next = I_WR_DATA[MAC_DEFER_BIT];
          end
        end
        // RQ10 analog gamma bytes
        CTX_POS: pos_we = idx_reg < 7'(ANALOG_LEN);
        CTX_NEG: neg_we = idx_reg < 7'(ANALOG_LEN);
        // RQ8 coarse table store
        CTX_COARSE: coarse_we = idx_reg < 7'(COARSE_LEN);
        // RQ9 fine table store
        CTX_FINE: fine_we = idx_reg < 7'(FINE_LEN);
        default: ;
      endcase
    end
    // Sleep-out leaves the panel blank until it takes effect, so apply it now
    if (I_WR_STB && !I_IS_PARAM && I_WR_DATA == CMD_SLEEP_OUT)
      sleep_next = 1'b0;
    else if (apply)
      sleep_next = sh_sleep_reg;
    if (apply) begin
      part_next = sh_part_reg;
      on_next = sh_on_reg;
      idle_next = sh_idle_reg;
      gsel_next = sh_gsel_reg;
      as_next = sh_area_reg[31:16];
      ae_next = sh_area_reg[15:0];
      // RQ5 bit 4 at vsync
      mac_next[MAC_DEFER_BIT] = sh_mac4_reg;
    end
    if (I_RD_STB && ctx_reg == CTX_READ) begin
      rd_valid_next = 1'b1;
      idx_next = (idx_reg == 7'h7f) ? idx_reg : idx_reg + 7'd1;
      rd_data_next = RD_DUMMY;
      case (rd_cmd_reg)
        // RQ11 dummy, zero, codes
        CMD_RD_ID4: begin
          case (idx_reg)
            7'd1: rd_data_next = ID4_FIXED;
            7'd2: rd_data_next = ID4_CODE_HI;
            7'd3: rd_data_next = ID4_CODE_LO;
            default: rd_data_next = RD_DUMMY;
          endcase
        end
        CMD_RD_STATUS: begin
          if (idx_reg == 7'd1) rd_data_next = power_byte;
          if (idx_reg == 7'd2) rd_data_next = O_MEMORY_ACCESS_CONTROL;
        end
        CMD_RD_POWER: if (idx_reg == 7'd1) rd_data_next = power_byte;
        CMD_RD_MAC: begin
          if (idx_reg == 7'd1) rd_data_next = O_MEMORY_ACCESS_CONTROL;
        end
        default: rd_data_next = RD_DUMMY;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctx_reg <= CTX_IDLE;
      idx_reg <= '0;
      rd_cmd_reg <= CMD_NOP;
      sh_sleep_reg <= 1'b1;
      sh_part_reg <= 1'b0;
      sh_on_reg <= 1'b0;
      sh_idle_reg <= 1'b0;
      sh_mac4_reg <= RST_MAC[MAC_DEFER_BIT];
      sh_gsel_reg <= RST_GAMMA_SEL;
      sh_area_reg <= {RST_AREA_START, RST_AREA_END};
      O_SLEEP_IN <= 1'b1;
      O_PARTIAL <= 1'b0;
      O_DISP_ON <= 1'b0;
      O_IDLE <= 1'b0;
      O_GAMMA_SEL <= RST_GAMMA_SEL;
      O_AREA_START <= RST_AREA_START;
      O_AREA_END <= RST_AREA_END;
      O_MEMORY_ACCESS_CONTROL <= RST_MAC;
      O_FACTORY_STB <= 1'b0;
      O_FACTORY_CODE <= CMD_NOP;
      O_RD_VALID <= 1'b0;
      O_RD_DATA <= RD_DUMMY;
    end else begin
      ctx_reg <= ctx_next;
      idx_reg <= idx_next;
      rd_cmd_reg <= rd_cmd_next;
      sh_sleep_reg <= sh_sleep_next;
      sh_part_reg <= sh_part_next;
      sh_on_reg <= sh_on_next;
      sh_idle_reg <= sh_idle_next;
      sh_mac4_reg <= sh_mac4_next;
      sh_gsel_reg <= sh_gsel_next;
      sh_area_reg <= sh_area_next;
      O_SLEEP_IN <= sleep_next;
      O_PARTIAL <= part_next;
      O_DISP_ON <= on_next;
      O_IDLE <= idle_next;
      O_GAMMA_SEL <= gsel_next;
      O_AREA_START <= as_next;
      O_AREA_END <= ae_next;
      O_MEMORY_ACCESS_CONTROL <= mac_next;
      O_FACTORY_STB <= fact_stb_next;
      O_FACTORY_CODE <= fact_code_next;
      O_RD_VALID <= rd_valid_next;
      O_RD_DATA <= rd_data_next;
    end
  end

  // Tables hold data only; reset clears them so lookups are defined
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      for (int i = 0; i < ANALOG_LEN; i++) begin
        pos_tab[i] <= '0;
        neg_tab[i] <= '0;
      end
      for (int i = 0; i < COARSE_LEN; i++) coarse_tab[i] <= '0;
      for (int i = 0; i < FINE_LEN; i++) fine_tab[i] <= '0;
      O_POS_GAMMA <= '0;
      O_NEG_GAMMA <= '0;
      O_RED_COARSE_GAMMA_ENTRY <= '0;
      O_BLUE_COARSE_GAMMA_ENTRY <= '0;
      O_RED_FINE_GAMMA_ENTRY <= '0;
      O_BLUE_FINE_GAMMA_ENTRY <= '0;
    end else begin
      // RQ10 drop unused upper bits
      if (pos_we) pos_tab[idx_reg[3:0]] <= I_WR_DATA &
                                          analog_mask(idx_reg[3:0]);
      if (neg_we) neg_tab[idx_reg[3:0]] <= I_WR_DATA &
                                          analog_mask(idx_reg[3:0]);
      if (coarse_we) coarse_tab[idx_reg[3:0]] <= I_WR_DATA;
      if (fine_we) fine_tab[idx_reg[5:0]] <= I_WR_DATA;
      // Out-of-range lookups of the 15-entry tables read zero
      O_POS_GAMMA <= (I_LUT_IDX < 6'(ANALOG_LEN)) ?
                     pos_tab[I_LUT_IDX[3:0]] : 8'h00;
      O_NEG_GAMMA <= (I_LUT_IDX < 6'(ANALOG_LEN)) ?
                     neg_tab[I_LUT_IDX[3:0]] : 8'h00;
      // RQ8 red upper, blue lower
      O_RED_COARSE_GAMMA_ENTRY <= coarse_tab[I_LUT_IDX[3:0]][7:4];
      O_BLUE_COARSE_GAMMA_ENTRY <= coarse_tab[I_LUT_IDX[3:0]][3:0];
      O_RED_FINE_GAMMA_ENTRY <= fine_tab[I_LUT_IDX][7:4];
      O_BLUE_FINE_GAMMA_ENTRY <= fine_tab[I_LUT_IDX][3:0];
    end
  end
endmodule // dcd_decoder

// File: tb/dcd_asserts.sv
`timescale 1ns/1ps
module dcd_asserts
  import dcd_pkg::*;
#(
  parameter logic [7:0] ID4_CODE_LO = 8'ha5,
  parameter logic [255:0] FACT_AVAIL = '0
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  // Host side
  input wire logic I_WR_STB,
  input wire logic I_IS_PARAM,
  input wire logic [7:0] I_WR_DATA,
  input wire logic I_RD_STB,
  input wire logic O_RD_VALID,
  input wire logic [7:0] O_RD_DATA,
  input wire logic I_VSYNC,
  // Applied state
  input wire logic O_SLEEP_IN,
  input wire logic O_PARTIAL,
  input wire logic O_DISP_ON,
  input wire logic O_IDLE,
  input wire logic [7:0] O_GAMMA_SEL,
  input wire logic [7:0] O_MEMORY_ACCESS_CONTROL,
  input wire logic O_FACTORY_STB,
  input wire logic [7:0] O_FACTORY_CODE
);
  wire logic is_cmd = I_WR_STB & ~I_IS_PARAM;
  default clocking @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_B);
  chk_read_cause: assert property (O_RD_VALID |-> $past(I_RD_STB))
    else $error("read answer without a strobe");
  chk_factory_src: assert property (O_FACTORY_STB |-> $past(is_cmd) &&
    FACT_AVAIL[O_FACTORY_CODE] && O_FACTORY_CODE == $past(I_WR_DATA))
    else $error("reserved report without an enabled command");
  chk_factory_range: assert property (O_FACTORY_STB |->
    O_FACTORY_CODE inside {[8'hb0:8'hd9], [8'hde:8'hff]})
    else $error("reserved report outside the reserved ranges");
  chk_sleep_out: assert property (is_cmd && I_WR_DATA == CMD_SLEEP_OUT
    |=> !O_SLEEP_IN) else $error("sleep out not taken at once");
  chk_defer_hold: assert property (!O_SLEEP_IN && !I_VSYNC |=>
    $stable({O_DISP_ON, O_IDLE, O_PARTIAL, O_GAMMA_SEL,
    O_MEMORY_ACCESS_CONTROL[4]})) else $error("state moved without vsync");
  chk_mac_low: assert property (I_WR_STB && I_IS_PARAM &&
    $past(is_cmd && I_WR_DATA == CMD_MEM_ACC) |=>
    O_MEMORY_ACCESS_CONTROL[3:0] == $past(I_WR_DATA[3:0]))
    else $error("access control low bits not applied at once");
  chk_sleep_in_now: assert property ((is_cmd && I_WR_DATA == CMD_DISP_ON
    && O_SLEEP_IN) ##1 (!I_WR_STB && O_SLEEP_IN) |=> O_DISP_ON)
    else $error("display on late in sleep in");
  chk_id_read: assert property ((is_cmd && I_WR_DATA == CMD_RD_ID4)
    ##1 (I_RD_STB && !I_WR_STB) [*4] |=> O_RD_VALID &&
    O_RD_DATA == ID4_CODE_LO) else $error("fourth id byte wrong");
endmodule // dcd_asserts
bind dcd_decoder dcd_asserts #(.ID4_CODE_LO(ID4_CODE_LO),
  .FACT_AVAIL(FACT_AVAIL)) u_chk (.I_CORE_CLK(I_CORE_CLK),
  .I_RST_B(I_RST_B), .I_WR_STB(I_WR_STB), .I_IS_PARAM(I_IS_PARAM),
  .I_WR_DATA(I_WR_DATA), .I_RD_STB(I_RD_STB), .O_RD_VALID(O_RD_VALID),
  .O_RD_DATA(O_RD_DATA), .I_VSYNC(I_VSYNC), .O_SLEEP_IN(O_SLEEP_IN),
  .O_PARTIAL(O_PARTIAL), .O_DISP_ON(O_DISP_ON), .O_IDLE(O_IDLE),
  .O_GAMMA_SEL(O_GAMMA_SEL),
  .O_MEMORY_ACCESS_CONTROL(O_MEMORY_ACCESS_CONTROL),
  .O_FACTORY_STB(O_FACTORY_STB), .O_FACTORY_CODE(O_FACTORY_CODE));

// File: tb/dcd_host.sv
`timescale 1ns/1ps
module dcd_host (
  // Clock
  input wire logic clk,
  // Host strobes
  output logic wr_stb,
  output logic is_param,
  output logic [7:0] wr_data,
  output logic rd_stb,
  output logic vsync,
  // Read answer
  input wire logic rd_valid,
  input wire logic [7:0] rd_data
);
  logic [7:0] pbuf [65];
  logic [8:0] got [4];
  initial begin
    wr_stb = 1'b0;
    is_param = 1'b0;
    wr_data = 8'h00;
    rd_stb = 1'b0;
    vsync = 1'b0;
  end
  task automatic put(input logic p, input logic [7:0] d);
    @(posedge clk);
    #1;
    wr_stb = 1'b1;
    is_param = p;
    wr_data = d;
    rd_stb = 1'b0;
  endtask
  // Released bus shows a changed value so stale data cannot pass
  task automatic idle();
    @(posedge clk);
    #1;
    wr_stb = 1'b0;
    wr_data = ~wr_data;
  endtask
  task automatic load(input logic [7:0] c, input int n);
    put(1'b0, c);
    for (int i = 0; i < n; i++) put(1'b1, pbuf[i]);
    idle();
  endtask
  task automatic rd(input int n);
    for (int i = 0; i <= n; i++) begin
      @(posedge clk);
      #1;
      if (i > 0) got[i-1] = {rd_valid, rd_data};
      wr_stb = 1'b0;
      rd_stb = (i < n);
    end
  endtask
  task automatic pulse_vsync();
    @(posedge clk);
    #1 vsync = 1'b1;
    @(posedge clk);
    #1 vsync = 1'b0;
  endtask
endmodule // dcd_host

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import dcd_pkg::*;
  // Arbitrary device codes
  localparam logic [7:0] ID_HI = 8'h3c;
  localparam logic [7:0] ID_LO = 8'hc3;
  localparam logic [255:0] AVAIL = 256'h1 << 8'hc0;
  logic clk, rst_b, ws, ip, rs, vs, rdv, fst, slp, prt, don, idl;
  logic [5:0] idx;
  logic [7:0] wd, rdd, gsel, mac, fcode, pg, ng;
  logic [15:0] as, ae;
  logic [3:0] rc, bc, rf, bf;
  logic [7:0] ana [2][64];
  logic [7:0] crs [16];
  logic [7:0] fin [64];
  logic [7:0] ab [4];
  logic [7:0] bad [6] = '{8'h00, 8'h05, 8'hb0, 8'hd9, 8'hde, 8'hff};
  int cnt [4] = '{15, 15, 16, 64};
  int num_errors = 0;
  int n_checks = 0;
  dcd_decoder #(.ID4_CODE_HI(ID_HI), .ID4_CODE_LO(ID_LO),
    .FACT_AVAIL(AVAIL)) DUT (.I_CORE_CLK(clk), .I_RST_B(rst_b),
    .I_WR_STB(ws), .I_IS_PARAM(ip), .I_WR_DATA(wd), .I_RD_STB(rs),
    .O_RD_VALID(rdv), .O_RD_DATA(rdd), .I_VSYNC(vs), .O_SLEEP_IN(slp),
    .O_PARTIAL(prt), .O_DISP_ON(don), .O_IDLE(idl), .O_GAMMA_SEL(gsel),
    .O_AREA_START(as), .O_AREA_END(ae), .O_MEMORY_ACCESS_CONTROL(mac),
    .O_FACTORY_STB(fst), .O_FACTORY_CODE(fcode), .I_LUT_IDX(idx),
    .O_POS_GAMMA(pg), .O_NEG_GAMMA(ng), .O_RED_COARSE_GAMMA_ENTRY(rc),
    .O_BLUE_COARSE_GAMMA_ENTRY(bc), .O_RED_FINE_GAMMA_ENTRY(rf),
    .O_BLUE_FINE_GAMMA_ENTRY(bf));
  dcd_host host (.clk(clk), .wr_stb(ws), .is_param(ip), .wr_data(wd),
    .rd_stb(rs), .vsync(vs), .rd_valid(rdv), .rd_data(rdd));
  function automatic logic [7:0] ea(input int t, input int i);
    logic [7:0] m;
    case (i)
      1, 2, 12, 13: m = 8'h3f;
      4, 10: m = 8'h1f;
      6, 8: m = 8'h7f;
      7: m = 8'hff;
      default: m = 8'h0f;
    endcase
    return (i < 15) ? (ana[t][i] & m) : 8'h00;
  endfunction
  task automatic chk(input logic [35:0] got, input logic [35:0] exp,
    input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
  initial begin
    rst_b = 1'b0;
    idx = 6'h00;
    void'($urandom(32'h801d));
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    @(posedge clk);
    #5;
    chk({slp, prt, don, idl, gsel}, {4'b1000, RST_GAMMA_SEL}, "reset");
    // One byte past each count goes in to show it is dropped
    for (int t = 0; t < 4; t++) begin
      for (int i = 0; i < 65; i++) host.pbuf[i] = 8'($urandom());
      host.load(CMD_POS_GAMMA + 8'(t), cnt[t] + 1);
      for (int i = 0; i < 64; i++) begin
        if (t < 2) ana[t][i] = host.pbuf[i];
        if (t == 2 && i < 16) crs[i] = host.pbuf[i];
        if (t == 3) fin[i] = host.pbuf[i];
      end
    end
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      #1 idx = 6'(i);
      @(posedge clk);
      #5;
      chk({pg, ng}, {ea(0, i), ea(1, i)}, "analog");
      chk({rc, bc, rf, bf}, {crs[i % 16], fin[i]}, "digital");
    end
    $display("done tables");
    foreach (bad[k]) begin
      host.put(1'b0, bad[k]);
      host.put(1'b1, 8'h77);
      // The strobe stands only in the cycle after the command
      #4;
      chk(fst, 1'b0, "nop strobe");
      host.idle();
      // A wrongly kept byte would reach the applied state by now
      @(posedge clk);
      #5;
      chk({fcode, gsel}, {CMD_NOP, RST_GAMMA_SEL}, "nop");
    end
    host.put(1'b0, 8'hc0);
    host.idle();
    #4;
    chk({fst, fcode}, 9'h1c0, "reserved");
    $display("done codes");
    host.put(1'b0, CMD_DISP_ON);
    host.idle();
    host.put(1'b0, CMD_GAMMA_SET);
    host.put(1'b1, 8'h02);
    host.idle();
    @(posedge clk);
    #5;
    chk({don, gsel}, 9'h102, "sleep in");
    host.put(1'b0, CMD_SLEEP_OUT);
    host.put(1'b0, CMD_DISP_OFF);
    host.put(1'b0, CMD_IDLE_ON);
    host.put(1'b0, CMD_MEM_ACC);
    host.put(1'b1, 8'hff);
    host.idle();
    repeat (3) @(posedge clk);
    #5;
    chk({slp, don, idl, mac}, 11'h2ef, "pending");
    host.pulse_vsync();
    #4;
    chk({don, idl, mac}, 10'h1ff, "vsync");
    $display("done sleep");
    host.put(1'b0, CMD_RD_ID4);
    host.rd(4);
    chk({host.got[0], host.got[1], host.got[2], host.got[3]},
      {9'h100, 9'h100, 1'b1, ID_HI, 1'b1, ID_LO}, "id4");
    host.put(1'b0, CMD_RD_MAC);
    host.rd(2);
    chk({host.got[0], host.got[1]}, {9'h100, 9'h1ff}, "mac read");
    host.put(1'b0, CMD_RD_POWER);
    host.rd(2);
    chk({host.got[0], host.got[1]}, {9'h100, 9'h158}, "power");
    host.put(1'b0, CMD_DISP_ON);
    host.rd(1);
    chk(host.got[0][8], 1'b0, "stray read");
    $display("done reads");
    host.put(1'b0, CMD_AREA);
    for (int i = 0; i < 4; i++) begin
      ab[i] = 8'($urandom());
      host.put(1'b1, ab[i]);
    end
    host.put(1'b0, CMD_PARTIAL);
    host.idle();
    repeat (2) @(posedge clk);
    #5;
    chk({prt, don, as, ae}, 34'h0, "area held");
    host.pulse_vsync();
    #4;
    chk({prt, don, as, ae}, {2'b11, ab[0], ab[1], ab[2], ab[3]},
      "area");
    host.put(1'b0, CMD_RD_STATUS);
    host.rd(4);
    chk({host.got[0], host.got[1], host.got[2], host.got[3]},
      {9'h100, 9'h174, 9'h1ff, 9'h100}, "status");
    host.put(1'b0, 8'h0e);
    host.rd(2);
    chk({host.got[0], host.got[1]}, {9'h100, 9'h100}, "mode read");
    host.put(1'b0, CMD_SLEEP_IN);
    host.idle();
    repeat (2) @(posedge clk);
    #5;
    chk(slp, 1'b0, "sleep in held");
    host.pulse_vsync();
    #4;
    chk(slp, 1'b1, "sleep in");
    host.put(1'b0, CMD_NORMAL);
    host.put(1'b0, CMD_IDLE_OFF);
    host.idle();
    @(posedge clk);
    #5;
    chk({prt, idl}, 2'b00, "sleep in now");
    $display("done state");
    // Reset in mid-run must bring every applied value back
    @(posedge clk);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    @(posedge clk);
    #5;
    chk({slp, prt, don, idl, gsel, mac, fcode},
      {4'b1000, RST_GAMMA_SEL, RST_MAC, CMD_NOP}, "reset again");
    chk({as, ae}, {RST_AREA_START, RST_AREA_END}, "area reset");
    chk({rc, bc, rf, bf, pg, ng}, 32'h0, "table reset");
    $display("done reset");
    complete_run();
  end
endmodule // tb
